// ---- ptp_pkg.sv ----
// Package of constants and a helper function for the three-instance period timer block.
package ptp_pkg;

    // ------------------------------------------------------------------
    // Sizes.
    // ------------------------------------------------------------------
    localparam int unsigned NUM_TIMERS  = 3;
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned PRESC_W     = 6;
    localparam int unsigned POST_W      = 4;
    localparam int unsigned INSTR_DIV_W = 2;

    // ------------------------------------------------------------------
    // Register map, byte addresses; each timer owns a block of words.
    // ------------------------------------------------------------------
    localparam logic [7:0] TMR_STRIDE   = 8'h10;
    localparam logic [3:0] OFS_CTRL     = 4'h0;
    localparam logic [3:0] OFS_COUNT    = 4'h4;
    localparam logic [3:0] OFS_PERIOD   = 4'h8;
    localparam logic [7:0] OFS_IRQ_FLAG = 8'h30;
    localparam logic [7:0] OFS_IRQ_EN   = 8'h34;

    // ------------------------------------------------------------------
    // Control register fields and reset values.
    // ------------------------------------------------------------------
    localparam int unsigned CTL_PS_HI   = 6;
    localparam int unsigned CTL_PS_LO   = 3;
    localparam int unsigned CTL_RUN_BIT = 2;
    localparam int unsigned CTL_CK_HI   = 1;
    localparam int unsigned CTL_CK_LO   = 0;
    localparam logic [7:0]  CTL_WR_MASK = 8'h7f;
    localparam logic [7:0]  CTL_RESET   = 8'h00;
    localparam logic [7:0]  COUNT_RESET = 8'h00;
    localparam logic [7:0]  PERIOD_RESET = 8'hff;

    // Last count of the instruction clock divider, which divides hclk by four.
    localparam logic [INSTR_DIV_W-1:0] INSTR_LAST = 2'h3;

    // Prescale terminal counts for divide by 1, 4, 16 and 64.
    localparam logic [PRESC_W-1:0] PRESC_LAST_1  = 6'h00;
    localparam logic [PRESC_W-1:0] PRESC_LAST_4  = 6'h03;
    localparam logic [PRESC_W-1:0] PRESC_LAST_16 = 6'h0f;
    localparam logic [PRESC_W-1:0] PRESC_LAST_64 = 6'h3f;

    // AHB transfer type and response codes.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;

    // Prescale select code to terminal count.
    function automatic logic [PRESC_W-1:0] ptp_presc_last(input logic [1:0] sel);
        case (sel)
            2'h0:    ptp_presc_last = PRESC_LAST_1;
            2'h1:    ptp_presc_last = PRESC_LAST_4;
            2'h2:    ptp_presc_last = PRESC_LAST_16;
            default: ptp_presc_last = PRESC_LAST_64;
        endcase
    endfunction

endpackage

// ---- ptp_tmr_if.sv ----
// Interface carrying one timer's control, strobes and state.
`timescale 1ns/1ps
interface ptp_tmr_if;
    import ptp_pkg::*;
    logic              instr_tick;
    logic              sleep;
    logic [DATA_W-1:0] ctrl;
    logic              wr_count;
    logic              wr_period;
    logic              wr_ctrl;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] count;
    logic [DATA_W-1:0] period;
    logic              match;
    logic              flag_evt;

    modport core (input instr_tick, sleep, ctrl, wr_count, wr_period, wr_ctrl, wdata,
                  output count, period, match, flag_evt);
    modport regs (output instr_tick, sleep, ctrl, wr_count, wr_period, wr_ctrl, wdata,
                  input count, period, match, flag_evt);
endinterface

// ---- ptp_timer_core.sv ----
// One 8-bit period timer with prescaler and postscaler.
`timescale 1ns/1ps
module ptp_timer_core (
    input  wire logic hclk,
    input  wire logic hresetn,
    ptp_tmr_if.core   tif
);
    import ptp_pkg::*;

    logic [DATA_W-1:0]  count_r,  count_nxt;
    logic [DATA_W-1:0]  period_r, period_nxt;
    logic [PRESC_W-1:0] presc_r,  presc_nxt;
    logic [POST_W-1:0]  post_r,   post_nxt;
    logic               match_r,  match_nxt;
    logic               evt_r,    evt_nxt;
    logic               run;
    logic               tick;
    logic               clr_scalers;

    // ------------------------------------------------------------------
    // Counting.
    // ------------------------------------------------------------------

    // Counting needs the run bit, no sleep and an instruction clock edge.
    assign run = tif.ctrl[CTL_RUN_BIT] & ~tif.sleep & tif.instr_tick;
    assign tick = run & (presc_r == ptp_presc_last(tif.ctrl[CTL_CK_HI:CTL_CK_LO]));
    assign clr_scalers = tif.wr_count | tif.wr_ctrl;

    // Next state of prescaler, counter, period and postscaler.
    always_comb begin
        presc_nxt  = presc_r;
        count_nxt  = count_r;
        period_nxt = period_r;
        post_nxt   = post_r;
        match_nxt  = 1'b0;
        evt_nxt    = 1'b0;
        if (run) begin
            presc_nxt = tick ? '0 : presc_r + 1'b1;
        end
        if (tick) begin
            if (count_r == period_r) begin
                count_nxt = '0;
                match_nxt = 1'b1;
                if (post_r == tif.ctrl[CTL_PS_HI:CTL_PS_LO]) begin
                    post_nxt = '0;
                    evt_nxt  = 1'b1;
                end else begin
                    post_nxt = post_r + 1'b1;
                end
            end else begin
                count_nxt = count_r + 1'b1;
            end
        end
        // A software write overrides the counting of the same cycle.
        if (tif.wr_count) begin
            count_nxt = tif.wdata;
        end
        if (tif.wr_period) begin
            period_nxt = tif.wdata;
        end
        if (clr_scalers) begin
            presc_nxt = '0;
            post_nxt  = '0;
        end
    end

    // Registers of the timer.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_r  <= COUNT_RESET;
            period_r <= PERIOD_RESET;
            presc_r  <= '0;
            post_r   <= '0;
            match_r  <= 1'b0;
            evt_r    <= 1'b0;
        end else begin
            count_r  <= count_nxt;
            period_r <= period_nxt;
            presc_r  <= presc_nxt;
            post_r   <= post_nxt;
            match_r  <= match_nxt;
            evt_r    <= evt_nxt;
        end
    end

    assign tif.count    = count_r;
    assign tif.period   = period_r;
    assign tif.match    = match_r;
    assign tif.flag_evt = evt_r;

endmodule // ptp_timer_core

// ---- ptp_top.sv ----
// Three period timers behind an AHB-Lite slave, with interrupt flags and outputs.
`timescale 1ns/1ps
module ptp_top (
    input  wire logic                        hclk,
    input  wire logic                        hresetn,
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output logic                             hreadyout,
    output logic                             hresp,
    output logic [31:0]                      hrdata,
    input  wire logic                        sleep_mode,
    output logic                             irq,
    output logic [ptp_pkg::NUM_TIMERS-1:0]   pwm_time_base,
    output logic                             spi_shift_clk
);
    import ptp_pkg::*;

    // ------------------------------------------------------------------
    // Address decoding helpers.
    // ------------------------------------------------------------------

    // Returns the timer number of a timer block address, or NUM_TIMERS if none.
    function automatic logic [1:0] ptp_tmr_sel(input logic [7:0] a);
        logic [1:0] n;
        n = a[5:4];
        if ({2'h0, a[7:6]} != 4'h0 || n >= 2'(NUM_TIMERS)) begin
            ptp_tmr_sel = 2'(NUM_TIMERS);
        end else begin
            ptp_tmr_sel = n;
        end
    endfunction

    // True when the address hits a given register of a timer block.
    function automatic logic ptp_hit(input logic [7:0] a, input logic [3:0] ofs);
        ptp_hit = (ptp_tmr_sel(a) != 2'(NUM_TIMERS)) && (a[3:0] == ofs);
    endfunction

    // ------------------------------------------------------------------
    // Signals.
    // ------------------------------------------------------------------
    logic                          wr_pend_r,  wr_pend_nxt;
    logic [7:0]                    wr_addr_r,  wr_addr_nxt;
    logic [31:0]                   rdata_r,    rdata_nxt;
    logic [INSTR_DIV_W-1:0]        idiv_r,     idiv_nxt;
    logic                          itick_r,    itick_nxt;
    logic [DATA_W-1:0]             ctrl_r   [NUM_TIMERS];
    logic [DATA_W-1:0]             ctrl_nxt [NUM_TIMERS];
    logic [NUM_TIMERS-1:0]         flag_r,     flag_nxt;
    logic [NUM_TIMERS-1:0]         en_r,       en_nxt;
    logic                          accept;
    logic                          rd_accept;
    logic [7:0]                    rd_addr;
    logic [NUM_TIMERS-1:0]         evt;
    logic [NUM_TIMERS-1:0]         match;
    logic [DATA_W-1:0]             cnt_val  [NUM_TIMERS];
    logic [DATA_W-1:0]             per_val  [NUM_TIMERS];

    ptp_tmr_if tif [NUM_TIMERS] ();

    // ------------------------------------------------------------------
    // AHB-Lite slave: zero wait states, always OKAY.
    // ------------------------------------------------------------------
    assign accept    = hsel & hready & (htrans == HTRANS_NONSEQ);
    assign rd_accept = accept & ~hwrite;
    assign rd_addr   = haddr[7:0];
    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;
    assign hrdata    = rdata_r;

    // Captures write addresses and builds read data during the address phase.
    always_comb begin
        wr_pend_nxt = accept & hwrite;
        wr_addr_nxt = accept ? haddr[7:0] : wr_addr_r;
        rdata_nxt   = rdata_r;
        if (rd_accept) begin
            rdata_nxt = '0;
            if (rd_addr == OFS_IRQ_FLAG) begin
                rdata_nxt = 32'(flag_r);
            end else if (rd_addr == OFS_IRQ_EN) begin
                rdata_nxt = 32'(en_r);
            end else if (ptp_hit(rd_addr, OFS_CTRL)) begin
                rdata_nxt = 32'(ctrl_r[ptp_tmr_sel(rd_addr)] & CTL_WR_MASK);
            end else if (ptp_hit(rd_addr, OFS_COUNT)) begin
                rdata_nxt = 32'(cnt_val[ptp_tmr_sel(rd_addr)]);
            end else if (ptp_hit(rd_addr, OFS_PERIOD)) begin
                rdata_nxt = 32'(per_val[ptp_tmr_sel(rd_addr)]);
            end
        end
    end

    // Bus-side registers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            rdata_r   <= 32'h0000_0000;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Instruction clock enable: one pulse every four hclk cycles.
    // ------------------------------------------------------------------
    always_comb begin
        idiv_nxt  = idiv_r + 1'b1;
        itick_nxt = (idiv_r == INSTR_LAST);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idiv_r  <= '0;
            itick_r <= 1'b0;
        end else begin
            idiv_r  <= idiv_nxt;
            itick_r <= itick_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Control registers, one per timer.
    // ------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NUM_TIMERS; i++) begin
            ctrl_nxt[i] = ctrl_r[i];
            if (wr_pend_r && ptp_hit(wr_addr_r, OFS_CTRL) && ptp_tmr_sel(wr_addr_r) == 2'(i)) begin
                ctrl_nxt[i] = hwdata[DATA_W-1:0] & CTL_WR_MASK;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
                ctrl_r[i] <= CTL_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
                ctrl_r[i] <= ctrl_nxt[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // Timer instances.
    // ------------------------------------------------------------------
    for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_tmr
        logic sel_me;

        assign sel_me = wr_pend_r && (ptp_tmr_sel(wr_addr_r) == 2'(g));

        // Drives the timer's controls and strobes from the bus side.
        assign tif[g].instr_tick = itick_r;
        assign tif[g].sleep      = sleep_mode;
        assign tif[g].ctrl       = ctrl_r[g];
        assign tif[g].wr_count   = sel_me && (wr_addr_r[3:0] == OFS_COUNT);
        assign tif[g].wr_period  = sel_me && (wr_addr_r[3:0] == OFS_PERIOD);
        assign tif[g].wr_ctrl    = sel_me && (wr_addr_r[3:0] == OFS_CTRL);
        assign tif[g].wdata      = hwdata[DATA_W-1:0];
        assign cnt_val[g]        = tif[g].count;
        assign per_val[g]        = tif[g].period;
        assign match[g]          = tif[g].match;
        assign evt[g]            = tif[g].flag_evt;

        ptp_timer_core u_core (
            .hclk    (hclk),
            .hresetn (hresetn),
            .tif     (tif[g])
        );
    end

    // ------------------------------------------------------------------
    // Timer outputs.
    // ------------------------------------------------------------------

    // Raw matches feed the PWM units; only the first timer clocks the SPI port.
    assign pwm_time_base = match;
    assign spi_shift_clk = match[0];

    // ------------------------------------------------------------------
    // Interrupt flags and enables.
    // ------------------------------------------------------------------

    // Flags set on postscaled events; a status read or a zero write clears them,
    // and a new event in the same cycle wins over the clear.
    always_comb begin
        flag_nxt = flag_r;
        en_nxt   = en_r;
        if (rd_accept && rd_addr == OFS_IRQ_FLAG) begin
            flag_nxt = '0;
        end
        if (wr_pend_r && wr_addr_r == OFS_IRQ_FLAG) begin
            flag_nxt = flag_nxt & hwdata[NUM_TIMERS-1:0];
        end
        if (wr_pend_r && wr_addr_r == OFS_IRQ_EN) begin
            en_nxt = hwdata[NUM_TIMERS-1:0];
        end
        flag_nxt = flag_nxt | evt;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_r <= '0;
            en_r   <= '0;
        end else begin
            flag_r <= flag_nxt;
            en_r   <= en_nxt;
        end
    end

    // Interrupt is high while any enabled flag is set.
    assign irq = |(flag_r & en_r);

endmodule // ptp_top

// ---- ptp_assertions.sv ----
// Checker of the timer block's bus, interrupt and match outputs.
`timescale 1ns/1ps
module ptp_assertions (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        sleep_mode,
    input wire logic        irq,
    input wire logic [2:0]  pwm_time_base,
    input wire logic        spi_shift_clk
);
    // -------------------------------------------------
    // Data phase tracking of the last taken request.
    // -------------------------------------------------
    logic       dv_r;
    logic       dw_r;
    logic [7:0] da_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dv_r <= 1'b0;
            dw_r <= 1'b0;
            da_r <= 8'h00;
        end else begin
            dv_r <= hsel && hready && htrans == 2'h2;
            dw_r <= hwrite;
            da_r <= haddr[7:0];
        end
    end
    // Decoded data phases of interest.
    wire en_wr  = dv_r && dw_r && da_r == 8'h34;
    wire en_wr0 = en_wr && hwdata[2:0] == 3'h0;
    wire fl_wr0 = dv_r && dw_r && da_r == 8'h30 && hwdata[2:0] == 3'h0;
    wire rd_ctl = dv_r && !dw_r && da_r[3:0] == 4'h0 && da_r[7:4] < 4'h3;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_spi; spi_shift_clk == pwm_time_base[0]; endproperty
    a_spi: assert property (p_spi) else $error("shift clock differs from timer 0 match");
    property p_pulse; pwm_time_base != 3'h0 |=> (pwm_time_base & $past(pwm_time_base)) == 3'h0; endproperty
    a_pulse: assert property (p_pulse) else $error("match pulse longer than one cycle");
    property p_gap; pwm_time_base[0] |=> (!pwm_time_base[0]) [*3]; endproperty
    a_gap: assert property (p_gap) else $error("matches closer than one instruction cycle");
    property p_sleep; sleep_mode [*3] |-> pwm_time_base == 3'h0; endproperty
    a_sleep: assert property (p_sleep) else $error("match while asleep");
    property p_mask; en_wr0 |=> !irq; endproperty
    a_mask: assert property (p_mask) else $error("interrupt with all enables clear");
    // The flag follows its match pulse by one cycle, so a match of the previous cycle may legally win over the clear.
    property p_clr; fl_wr0 |=> $past(pwm_time_base) != 3'h0 || !irq; endproperty
    a_clr: assert property (p_clr) else $error("flag not cleared by zero write");
    property p_rise; $rose(irq) |-> $past(pwm_time_base) != 3'h0 || $past(en_wr); endproperty
    a_rise: assert property (p_rise) else $error("interrupt rose without a match");
    property p_ctl; rd_ctl |-> hrdata[31:7] == 25'h0; endproperty
    a_ctl: assert property (p_ctl) else $error("control read shows bit 7 or above");
endmodule // ptp_assertions

// ---- ptp_far_model.sv ----
// Far-side model: PWM units timing periods and the SPI port counting shift clocks.
`timescale 1ns/1ps
module ptp_far_model (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [2:0]       pwm_time_base,
    input  wire logic             spi_shift_clk,
    output logic      [2:0][15:0] gap_r,
    output logic      [2:0][15:0] pcnt_r,
    output logic      [15:0]      spi_r
);
    logic [2:0][15:0] age_r;
    // Each PWM unit measures its period between unscaled match pulses.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            age_r  <= '0;
            gap_r  <= '0;
            pcnt_r <= '0;
            spi_r  <= 16'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                age_r[i] <= pwm_time_base[i] ? 16'h1 : age_r[i] + 16'h1;
                if (pwm_time_base[i]) begin
                    gap_r[i]  <= age_r[i];
                    pcnt_r[i] <= pcnt_r[i] + 16'h1;
                end
            end
            spi_r <= spi_r + {15'h0, spi_shift_clk};
        end
    end
endmodule // ptp_far_model

// ---- ptp_top_tb.sv ----
// Self-checking testbench of the three-timer block.
`timescale 1ns/1ps
module ptp_top_tb;
    import ptp_pkg::*;
    logic             hclk, hresetn, hsel, hwrite, sleep_mode;
    logic             hreadyout, hresp, irq, spi_shift_clk;
    logic [31:0]      haddr, hwdata, hrdata, rd, c;
    logic [1:0]       htrans;
    logic [2:0]       hsize, pwm_time_base;
    logic [2:0][15:0] gap, pcnt;
    logic [15:0]      spi, p0;
    logic [7:0]       b;
    int               failures, checks, k;
    int               ns[3] = '{0, 5, 15};

    always #2 hclk = ~hclk;

    ptp_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
                   .hready(hreadyout), .hreadyout, .hresp, .hrdata, .sleep_mode, .irq,
                   .pwm_time_base, .spi_shift_clk);
    ptp_far_model i_far (.hclk, .hresetn, .pwm_time_base, .spi_shift_clk,
                         .gap_r(gap), .pcnt_r(pcnt), .spi_r(spi));

    // -------------------------------------------------
    // Reporting and bus tasks.
    // -------------------------------------------------
    task automatic wrap_up;
        $display("Counts: checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Advances edges until ready is sampled high; a stuck bus ends the run.
    task automatic tick_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (n >= 64) begin
            failures++;
            wrap_up();
        end
    endtask

    // One single AHB transfer; read data lands in rd.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        tick_rdy();
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        tick_rdy();
        rd = hrdata;
    endtask

    // Waits, bounded, for timer t to pulse twice so that its gap is clean.
    task automatic two_pulses(input int t);
        int n;
        n = 0;
        p0 = pcnt[t];
        while (pcnt[t] - p0 < 16'd2 && n < 4000) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 4000) begin
            failures++;
            wrap_up();
        end
    endtask

    initial begin
        {hclk, hresetn, hsel, hwrite, sleep_mode, haddr, htrans, hwdata} = '0;
        hsize = 3'h2;
        failures = 0;
        checks = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        // Reset values, read-only bit and unmapped space.
        for (b = 8'h0; b < 8'h30; b += 8'h10) begin
            xfer(1'b0, b, 0);
            chk(rd, 32'h0);
            xfer(1'b0, b + 8'h4, 0);
            chk(rd, 32'h0);
            xfer(1'b0, b + 8'h8, 0);
            chk(rd, 32'hff);
            xfer(1'b1, b, 32'hff);
            xfer(1'b0, b, 0);
            chk(rd, 32'h7f);
            xfer(1'b1, b, 0);
        end
        xfer(1'b0, 8'h40, 0);
        chk(rd, 32'h0);
        $display("Test reset done");
        // Match interval for each prescale code, spread over all timers.
        for (k = 0; k < 4; k++) begin
            b = 8'((k % 3) * 16);
            xfer(1'b1, b + 8'h8, 2);
            xfer(1'b1, b + 8'h4, 0);
            xfer(1'b1, b, 32'h4 | 32'(k));
            two_pulses(k % 3);
            chk({16'h0, gap[k % 3]}, 32'd12 << (2 * k));
            xfer(1'b1, b, 0);
        end
        $display("Test prescale done");
        // Postscale ratios seen as matches per interrupt.
        xfer(1'b1, 8'h08, 0);
        xfer(1'b1, 8'h04, 0);
        xfer(1'b1, 8'h34, 1);
        for (int j = 0; j < 3; j++) begin
            xfer(1'b1, 8'h00, 0);
            xfer(1'b1, 8'h30, 0);
            p0 = pcnt[0];
            xfer(1'b1, 8'h00, 32'({ns[j][3:0], 3'b100}));
            k = 0;
            while (irq !== 1'b1 && k < 500) begin
                @(posedge hclk);
                k++;
            end
            if (irq !== 1'b1) begin
                failures++;
                wrap_up();
            end
            @(posedge hclk);
            chk({16'h0, pcnt[0] - p0}, 32'(ns[j] + 1));
        end
        repeat (20) @(posedge hclk);
        chk({31'h0, irq}, 32'h1);
        xfer(1'b0, 8'h30, 0);
        chk(rd, 32'h1);
        xfer(1'b1, 8'h34, 0);
        repeat (80) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b0, 8'h30, 0);
        chk(rd, 32'h1);
        $display("Test postscale done");
        // Sleep and stop freeze the count; control writes keep it.
        xfer(1'b1, 8'h08, 32'hff);
        xfer(1'b1, 8'h00, 32'h4);
        repeat (40) @(posedge hclk);
        sleep_mode <= 1'b1;
        xfer(1'b0, 8'h04, 0);
        c = rd;
        repeat (50) @(posedge hclk);
        xfer(1'b0, 8'h04, 0);
        chk(rd, c);
        xfer(1'b0, 8'h08, 0);
        chk(rd, 32'hff);
        sleep_mode <= 1'b0;
        xfer(1'b1, 8'h00, 0);
        xfer(1'b0, 8'h04, 0);
        c = rd;
        repeat (50) @(posedge hclk);
        xfer(1'b1, 8'h00, 32'h78);
        xfer(1'b0, 8'h04, 0);
        chk(rd, c);
        chk({16'h0, spi}, {16'h0, pcnt[0]});
        $display("Test freeze done");
        wrap_up();
    end
endmodule // ptp_top_tb

bind ptp_top ptp_assertions i_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
                                   .hwdata, .hrdata, .sleep_mode, .irq, .pwm_time_base, .spi_shift_clk);
